// >>> src/uwf_pkg.sv
/*
  uwf_pkg: register offsets, register layouts, reset values, counts
  and state codes of the serial transceiver wakeup/flag block.
  Assumes an APB master with 32-bit data and a 125 MHz bus clock.
*/
// Contract
// R1: sleep blocks every receiver flag except idle when idle_flag_in_sleep set.
// R2: idle wake mode clears sleep after 10 or 11 idle bit times.
// R3: waking idle sets idle flag only when idle_flag_in_sleep is 1.
// R4: idle count starts after start bit, or after stop bit if selected.
// R5: address mode: MSB one clears sleep before stop; character is kept.
// R6: three requests: transmit, receive, error; ten maskable pollable sources.
// R7: transmit request while buffer empty and its enable set.
// R8: complete flag sets when all sent and line idle; optional request.
// R9: status read with buffer full, then data read, clears buffer full.
// R10: same sequence clears idle; idle rearms only after a new character.
// R11: noise, framing, parity flags set with buffer full, never on overrun.
// R12: character arriving while buffer full sets overrun and is dropped.
// R13: enabled receiver sets edge flag on active edge; write one clears.
// R14: nine-bit mode uses tx_ninth_bit out and rx_ninth_bit in.
// R15: tx_ninth_bit copied into shifter together with buffer data.
// R16: software writes tx_ninth_bit before data_register.
// R17: stop halts clocks; deep stop loses registers, shallow keeps them.
// R18: edge detector runs in shallow stop and wakes cpu if enabled.
// R19: software does not enter stop while a character is moving.
// R20: loop mode feeds transmitter into receiver and frees rx_pin.
// R21: single wire joins receiver to transmitter and tx_pin; frees rx_pin.
// R22: single wire direction: 0 tx_pin is input, 1 transmitter drives it.
// R23: framing error set blocks new characters from the receive buffer.
// R24: reset clears flags and sleep, disables loop, selects 8-bit data; tx_buffer_empty and tx_complete_flag reset to 1 instead.
package uwf_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [4:0] OFS_CTL1  = 5'h00;
  localparam logic [4:0] OFS_CTL2  = 5'h04;
  localparam logic [4:0] OFS_STAT1 = 5'h08;
  localparam logic [4:0] OFS_STAT2 = 5'h0C;
  localparam logic [4:0] OFS_CTL3  = 5'h10;
  localparam logic [4:0] OFS_DATA  = 5'h14;
  localparam logic [4:0] OFS_BAUD  = 5'h18;
  // ==========================================================
  // register layouts, msb first
  typedef struct packed {
    logic data_width_select;
    logic sleep_exit_method;
    logic idle_count_start_select;
    logic internal_loop_select;
    logic rx_source_select;
    logic parity_enable;
    logic parity_odd;
    logic idle_flag_in_sleep;
  } uwf_ctl1_type;
  typedef struct packed {
    logic tx_empty_irq_enable;
    logic tx_done_irq_enable;
    logic rx_full_irq_enable;
    logic idle_irq_enable;
    logic tx_on;
    logic rx_on_control;
    logic rx_sleep_request;
    logic rx_edge_irq_enable;
  } uwf_ctl2_type;
  typedef struct packed {
    logic tx_ninth_bit;
    logic pin_direction_tx;
    logic break_irq_enable;
    logic overrun_irq_enable;
    logic noise_irq_enable;
    logic framing_irq_enable;
    logic parity_irq_enable;
  } uwf_ctl3_type;
  typedef struct packed {
    logic tx_buffer_empty;
    logic tx_complete_flag;
    logic rx_buffer_full;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_error_flag;
    logic parity_error_flag;
  } uwf_stat1_type;
  // status 2 bit positions
  localparam int BIT_BREAK  = 7;
  localparam int BIT_EDGE   = 6;
  localparam int BIT_RXBUSY = 0;
  // ==========================================================
  // reset values
  localparam logic [7:0]  CTL1_RST  = 8'h00;
  localparam logic [7:0]  CTL2_RST  = 8'h00;
  localparam logic [6:0]  CTL3_RST  = 7'h00;
  localparam logic [7:0]  STAT1_RST = 8'hC0;
  localparam logic [12:0] BAUD_RST  = 13'h0004;
  // ==========================================================
  // bit timing counts in 16x sample ticks and bit times
  localparam logic [3:0] OVS_LAST  = 4'hF;
  localparam logic [3:0] SMP_FIRST = 4'h8;
  localparam logic [3:0] SMP_LAST  = 4'hA;
  localparam logic [3:0] BITS_8    = 4'h8;
  localparam logic [3:0] BITS_9    = 4'h9;
  localparam logic [3:0] CHAR_8    = 4'hA;
  localparam logic [3:0] CHAR_9    = 4'hB;
  // ==========================================================
  // states and power modes
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b01,
    RX_FRAME = 2'b10
  } uwf_rx_type;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } uwf_tx_type;
  typedef enum logic [1:0] {
    STOP_RUN     = 2'h0,
    STOP_SHALLOW = 2'h1,
    STOP_DEEP    = 2'h2
  } uwf_stop_type;
endpackage

// >>> src/uwf_top.sv
/*
  uwf_top: serial transceiver with receiver sleep and wakeup, grouped
  interrupt requests, nine-bit data, stop-mode handling, loop and
  single-wire modes, behind an APB register slave.
  Assumes all inputs synchronous to clk; stop_mode from the power
  controller; rx and tx pins resolved by the surrounding pad logic.
*/
`timescale 1ns/10ps
module uwf_top (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [4:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // serial pins
  input  wire logic                  rx_pin,
  input  wire logic                  tx_pin_in,
  output logic                       tx_pin_out,
  output logic                       tx_pin_oe,
  output logic                       rx_pin_release,
  // power mode and requests
  input  wire uwf_pkg::uwf_stop_type stop_mode,
  output logic                       irq_tx,
  output logic                       irq_rx,
  output logic                       irq_err,
  output logic                       wake_request
);
  // ==========================================================
  // state
  uwf_pkg::uwf_ctl1_type  ctl1;
  uwf_pkg::uwf_ctl2_type  ctl2;
  uwf_pkg::uwf_ctl3_type  ctl3;
  uwf_pkg::uwf_stat1_type stat1, next_stat1, seen, clr;
  uwf_pkg::uwf_rx_type    rx_state;
  uwf_pkg::uwf_tx_type    tx_state;
  logic [12:0] baud_div, baud_cnt;
  logic        tick, rx_prev, edge_flag, brk_flag, idle_armed;
  logic [3:0]  rx_phase, rx_bit, idle_cnt, tx_phase, tx_bit;
  logic [2:0]  rx_hist, rx_smp;
  logic [8:0]  rx_shift, rx_data;
  logic        rx_noise, pre_q;
  logic [10:0] tx_shift;
  logic [7:0]  tx_buf;

  // ==========================================================
  // power modes: clocks stop in any stop mode, deep one wipes
  logic run, alive, shallow, wipe;
  assign run     = (stop_mode == uwf_pkg::STOP_RUN);        // R17
  assign shallow = (stop_mode == uwf_pkg::STOP_SHALLOW);
  assign alive   = run | shallow;
  assign wipe    = ~alive;                                  // R17

  // ==========================================================
  // apb decode; pready comes one cycle into the access phase
  logic acc, wr_go, rd_go, mapped;
  logic hit_c1, hit_c2, hit_s1, hit_s2, hit_c3, hit_d, hit_b;
  assign acc    = psel & penable;
  assign wr_go  = acc & pready & pwrite;
  assign rd_go  = acc & pready & ~pwrite;
  assign hit_c1 = (paddr == uwf_pkg::OFS_CTL1);
  assign hit_c2 = (paddr == uwf_pkg::OFS_CTL2);
  assign hit_s1 = (paddr == uwf_pkg::OFS_STAT1);
  assign hit_s2 = (paddr == uwf_pkg::OFS_STAT2);
  assign hit_c3 = (paddr == uwf_pkg::OFS_CTL3);
  assign hit_d  = (paddr == uwf_pkg::OFS_DATA);
  assign hit_b  = (paddr == uwf_pkg::OFS_BAUD);
  assign mapped = hit_c1 | hit_c2 | hit_s1 | hit_s2 | hit_c3 | hit_d
                | hit_b;

  // write strobes and read side effects
  logic we_c1, we_c2, we_s2, we_c3, we_d, we_b, rd_s1, rd_d;
  assign we_c1 = wr_go & hit_c1;
  assign we_c2 = wr_go & hit_c2;
  assign we_s2 = wr_go & hit_s2;
  assign we_c3 = wr_go & hit_c3;
  assign we_d  = wr_go & hit_d;
  assign we_b  = wr_go & hit_b;
  assign rd_s1 = rd_go & hit_s1;
  assign rd_d  = rd_go & hit_d;
  assign clr   = rd_d ? seen : '0;                        // R9 R10

  // read mux; unused upper bits read as zero
  logic [7:0]  stat2_rd;
  logic [31:0] rd_mux;
  always_comb begin
    stat2_rd                      = 8'h00;
    stat2_rd[uwf_pkg::BIT_BREAK]  = brk_flag;
    stat2_rd[uwf_pkg::BIT_EDGE]   = edge_flag;
    stat2_rd[uwf_pkg::BIT_RXBUSY] = (rx_state == uwf_pkg::RX_FRAME);
  end
  assign rd_mux = hit_c1 ? {24'h0, ctl1}
                : hit_c2 ? {24'h0, ctl2}
                : hit_s1 ? {24'h0, stat1}
                : hit_s2 ? {24'h0, stat2_rd}
                : hit_c3 ? {24'h0, rx_data[8], ctl3}          // R14
                : hit_d  ? {24'h0, rx_data[7:0]}
                : hit_b  ? {19'h0, baud_div}
                : 32'h0;

  // bus answer; no answer while the module clock is halted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready & run;
      prdata  <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h0;
      pslverr <= acc & ~pready & run & ~mapped;
    end
  end

  // ==========================================================
  // control registers; hardware may clear the sleep request
  logic addr_wake, idle_wake, idle_hit;
  always_ff @(posedge clk or posedge rst) begin
    if (rst | wipe) begin                                     // R24
      ctl1     <= uwf_pkg::CTL1_RST;
      ctl2     <= uwf_pkg::CTL2_RST;
      ctl3     <= uwf_pkg::CTL3_RST;
      baud_div <= uwf_pkg::BAUD_RST;
    end else if (run) begin
      if (we_c1) ctl1 <= pwdata[7:0];
      if (we_c3) ctl3 <= pwdata[6:0];
      if (we_b) baud_div <= pwdata[12:0];
      if (we_c2) ctl2 <= pwdata[7:0];
      else if (addr_wake | idle_wake)
        ctl2.rx_sleep_request <= 1'b0;                     // R2 R5
    end
  end

  // ==========================================================
  // 16x sample tick divider
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_cnt <= 13'h0;
      tick     <= 1'b0;
    end else if (run & (baud_cnt >= baud_div)) begin
      baud_cnt <= 13'h0;
      tick     <= 1'b1;
    end else begin
      baud_cnt <= run ? baud_cnt + 13'h1 : baud_cnt;
      tick     <= 1'b0;
    end
  end

  // ==========================================================
  // receive source: pin, internal loop, or single wire
  logic loop_on, single, rx_src, sleep;
  assign loop_on = ctl1.internal_loop_select;
  assign single  = loop_on & ctl1.rx_source_select;
  assign rx_src  = ~loop_on ? rx_pin
                 : ~ctl1.rx_source_select ? tx_pin_out          // R20
                 : ctl3.pin_direction_tx ? tx_pin_out           // R21 R22
                 : tx_pin_in;                                   // R22
  assign sleep   = ctl2.rx_sleep_request;

  // ==========================================================
  // receiver framing and majority sampling
  logic       maj, disagree, bit_end, in_frame, at_msb, at_stop;
  logic       start_seen, frame_end, false_start;
  logic [3:0] data_bits, char_len;
  logic [8:0] rx_char;
  assign maj = (rx_smp[0] & rx_smp[1]) | (rx_smp[0] & rx_smp[2])
             | (rx_smp[1] & rx_smp[2]);
  assign disagree   = (|rx_smp) & ~(&rx_smp);
  assign in_frame   = (rx_state == uwf_pkg::RX_FRAME);
  assign bit_end    = tick & (rx_phase == uwf_pkg::OVS_LAST);
  assign data_bits  = ctl1.data_width_select ? uwf_pkg::BITS_9
                                             : uwf_pkg::BITS_8; // R14
  assign char_len   = ctl1.data_width_select ? uwf_pkg::CHAR_9
                                             : uwf_pkg::CHAR_8; // R2
  assign at_msb     = (rx_bit == data_bits);
  assign at_stop    = (rx_bit == data_bits + 4'h1);
  assign start_seen = tick & ~in_frame & (&rx_hist) & ~rx_src;
  assign frame_end  = bit_end & in_frame & at_stop;
  assign false_start = bit_end & in_frame & (rx_bit == 4'h0) & maj;
  assign rx_char    = ctl1.data_width_select ? rx_shift
                                             : {1'b0, rx_shift[8:1]};
  // msb one wakes the receiver before the stop bit
  assign addr_wake  = bit_end & in_frame & at_msb & maj & sleep
                    & ctl1.sleep_exit_method;                   // R5

  // the receiver runs only while the receive enable is set
  always_ff @(posedge clk or posedge rst) begin
    if (rst | wipe) begin
      rx_state <= uwf_pkg::RX_IDLE;
      rx_phase <= 4'h0;
      rx_bit   <= 4'h0;
      rx_hist  <= 3'b111;
      rx_smp   <= 3'b111;
      rx_shift <= 9'h000;
      rx_noise <= 1'b0;
    end else if (run & ~ctl2.rx_on_control) begin
      rx_state <= uwf_pkg::RX_IDLE;
    end else if (run & tick) begin
      rx_hist  <= {rx_hist[1:0], rx_src};
      rx_phase <= start_seen ? 4'h1 : rx_phase + 4'h1;
      if ((rx_phase >= uwf_pkg::SMP_FIRST) &
          (rx_phase <= uwf_pkg::SMP_LAST))
        rx_smp <= {rx_smp[1:0], rx_src};
      unique case (rx_state)
        uwf_pkg::RX_IDLE: begin
          if (start_seen) begin
            rx_state <= uwf_pkg::RX_FRAME;
            rx_bit   <= 4'h0;
            rx_noise <= 1'b0;
          end
        end
        uwf_pkg::RX_FRAME: begin
          if (rx_phase == uwf_pkg::OVS_LAST) begin
            rx_noise <= rx_noise | disagree;
            rx_bit   <= rx_bit + 4'h1;
            if ((rx_bit != 4'h0) & ~at_stop)
              rx_shift <= {maj, rx_shift[8:1]};
            if (false_start | at_stop)
              rx_state <= uwf_pkg::RX_IDLE;
            if (at_stop)
              rx_hist <= 3'b111;  // lets a new start follow at once
          end
        end
      endcase
    end
  end

  // ==========================================================
  // idle line counter in bit times
  logic       cnt_hold0;
  logic [3:0] idle_inc;
  assign cnt_hold0 = ~maj | (in_frame & ctl1.idle_count_start_select);
  assign idle_inc  = (idle_cnt == char_len) ? idle_cnt
                                            : idle_cnt + 4'h1;
  assign idle_hit  = bit_end & ~cnt_hold0
                   & (idle_cnt == char_len - 4'h1);             // R4
  assign idle_wake = idle_hit & sleep & ~ctl1.sleep_exit_method; // R2

  always_ff @(posedge clk or posedge rst) begin
    if (rst | wipe)
      idle_cnt <= 4'h0;
    else if (run & bit_end & ctl2.rx_on_control)
      idle_cnt <= cnt_hold0 ? 4'h0 : idle_inc;                  // R4
  end

  // ==========================================================
  // character transfer into the receive buffer
  logic rx_take, rx_buffer_full_set, ovr_set, brk_set, idle_set, edge_set;
  logic nf_now, fe_now, pf_now;
  assign rx_take  = frame_end & ~sleep
                  & ~stat1.framing_error_flag;              // R1 R23
  assign rx_buffer_full_set = rx_take & ~stat1.rx_buffer_full;
  assign ovr_set  = rx_take & stat1.rx_buffer_full;            // R12
  assign nf_now   = rx_noise | disagree;
  assign fe_now   = ~maj;
  assign pf_now   = ctl1.parity_enable & ((^rx_char) ^ ctl1.parity_odd);
  assign brk_set  = frame_end & ~sleep & fe_now & (rx_char == 9'h000);
  // a waking idle stays silent unless allowed
  assign idle_set = idle_hit & idle_armed
                  & (~sleep | ctl1.idle_flag_in_sleep);  // R1 R3 R10
  assign edge_set = alive & ctl2.rx_on_control & ~sleep
                  & rx_prev & ~rx_src;                    // R13 R18

  // ==========================================================
  // transmitter
  logic tx_bit_end, tx_load, tx_last, tx_buffer_empty_set, tc_set, pre_set;
  logic [10:0] tx_frame;
  assign tx_bit_end = tick & (tx_phase == uwf_pkg::OVS_LAST);
  assign tx_load    = run & tick & (tx_state == uwf_pkg::TX_IDLE)
                    & ctl2.tx_on & (pre_q | ~stat1.tx_buffer_empty);
  assign tx_last    = tx_bit_end & (tx_state == uwf_pkg::TX_SHIFT)
                    & (tx_bit == char_len - 4'h1);
  assign tx_buffer_empty_set   = tx_load & ~pre_q;
  assign tc_set     = tx_last & stat1.tx_buffer_empty & ~pre_q; // R8
  assign pre_set    = we_c2 & pwdata[3] & ~ctl2.tx_on;
  // ninth bit travels with the buffer contents
  assign tx_frame   = pre_q ? 11'h7FF
                    : {1'b1, ctl1.data_width_select ? ctl3.tx_ninth_bit
                                                    : 1'b1,
                       tx_buf, 1'b0};                        // R14 R15

  always_ff @(posedge clk or posedge rst) begin
    if (rst | wipe) begin
      tx_state   <= uwf_pkg::TX_IDLE;
      tx_phase   <= 4'h0;
      tx_bit     <= 4'h0;
      tx_shift   <= 11'h7FF;
      tx_pin_out <= 1'b1;
    end else if (tx_load) begin
      tx_state   <= uwf_pkg::TX_SHIFT;
      tx_phase   <= 4'h0;
      tx_bit     <= 4'h0;
      tx_shift   <= tx_frame;                                 // R15
      tx_pin_out <= tx_frame[0];
    end else if (run & tick & (tx_state == uwf_pkg::TX_SHIFT)) begin
      tx_phase <= tx_phase + 4'h1;
      if (tx_last) begin
        tx_state   <= uwf_pkg::TX_IDLE;
        tx_pin_out <= 1'b1;
      end else if (tx_bit_end) begin
        tx_bit     <= tx_bit + 4'h1;
        tx_shift   <= {1'b1, tx_shift[10:1]};
        tx_pin_out <= tx_shift[1];
      end
    end
  end

  // ==========================================================
  // status flags; every hardware set wins over its clear
  assign next_stat1.tx_buffer_empty = tx_buffer_empty_set
         | (stat1.tx_buffer_empty & ~we_d);
  assign next_stat1.tx_complete_flag = tc_set
         | (stat1.tx_complete_flag & ~we_d & ~pre_set);
  assign next_stat1.rx_buffer_full = rx_buffer_full_set
         | (stat1.rx_buffer_full & ~clr.rx_buffer_full);       // R9
  assign next_stat1.idle_flag = idle_set
         | (stat1.idle_flag & ~clr.idle_flag);                 // R10
  assign next_stat1.overrun_flag = ovr_set
         | (stat1.overrun_flag & ~clr.overrun_flag);           // R12
  assign next_stat1.noise_flag = (rx_buffer_full_set & nf_now)
         | (stat1.noise_flag & ~clr.noise_flag);               // R11
  assign next_stat1.framing_error_flag = (rx_buffer_full_set & fe_now)
         | (stat1.framing_error_flag & ~clr.framing_error_flag); // R11
  assign next_stat1.parity_error_flag = (rx_buffer_full_set & pf_now)
         | (stat1.parity_error_flag & ~clr.parity_error_flag); // R11

  // status 1 and the read-sequence tracker
  always_ff @(posedge clk or posedge rst) begin
    if (rst | wipe) begin                                     // R24
      stat1      <= uwf_pkg::STAT1_RST;
      seen       <= '0;
      idle_armed <= 1'b0;
      rx_data    <= 9'h000;
    end else if (run) begin
      stat1 <= next_stat1;
      if (rd_s1) seen <= stat1;                             // R9 R10
      else if (rd_d) seen <= '0;
      if (rx_buffer_full_set) rx_data <= rx_char;                        // R14
      if (rx_buffer_full_set) idle_armed <= 1'b1;                        // R10
      else if (idle_set) idle_armed <= 1'b0;
    end
  end

  // edge and break flags, preamble queue, transmit buffer
  always_ff @(posedge clk or posedge rst) begin
    if (rst | wipe) begin
      rx_prev   <= 1'b1;
      edge_flag <= 1'b0;
      brk_flag  <= 1'b0;
      pre_q     <= 1'b0;
      tx_buf    <= 8'h00;
    end else begin
      rx_prev   <= rx_src;                                     // R18
      edge_flag <= edge_set
                 | (edge_flag & ~(we_s2 & pwdata[uwf_pkg::BIT_EDGE]));
      brk_flag  <= (run & brk_set)
                 | (brk_flag & ~(we_s2 & pwdata[uwf_pkg::BIT_BREAK]));
      pre_q     <= pre_set | (pre_q & ~tx_load);
      if (we_d) tx_buf <= pwdata[7:0];
    end
  end

  // ==========================================================
  // requests and pin control, all registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_tx         <= 1'b0;
      irq_rx         <= 1'b0;
      irq_err        <= 1'b0;
      wake_request   <= 1'b0;
      tx_pin_oe      <= 1'b0;
      rx_pin_release <= 1'b0;
    end else begin
      irq_tx  <= (ctl2.tx_empty_irq_enable & stat1.tx_buffer_empty)  // R7
               | (ctl2.tx_done_irq_enable & stat1.tx_complete_flag); // R8
      irq_rx  <= (ctl2.rx_full_irq_enable & stat1.rx_buffer_full)   // R6
               | (ctl2.idle_irq_enable & stat1.idle_flag)
               | (ctl2.rx_edge_irq_enable & edge_flag)
               | (ctl3.break_irq_enable & brk_flag);
      irq_err <= (ctl3.overrun_irq_enable & stat1.overrun_flag)     // R6
               | (ctl3.noise_irq_enable & stat1.noise_flag)
               | (ctl3.framing_irq_enable & stat1.framing_error_flag)
               | (ctl3.parity_irq_enable & stat1.parity_error_flag);
      wake_request <= shallow & edge_set
                    & ctl2.rx_edge_irq_enable;                 // R18
      // pin stays driven until a frame in progress has finished
      tx_pin_oe <= (ctl2.tx_on | (tx_state == uwf_pkg::TX_SHIFT))
                 & ~(single & ~ctl3.pin_direction_tx);         // R22
      rx_pin_release <= loop_on;                           // R20 R21
    end
  end
endmodule // uwf_top

// >>> test/uwf_asserts.sv
/* uwf_asserts: port checks on uwf_top.
   assumes one clock domain; bound below */
`timescale 1ns/10ps
module uwf_asserts (
  // clock, reset, bus answer
  input wire logic clk, rst, psel, penable, pready, pslverr,
  // pins, requests, power mode
  input wire logic tx_pin_out, rx_pin_release, irq_tx, irq_rx,
  input wire logic irq_err, wake_request,
  input wire uwf_pkg::uwf_stop_type stop_mode
);
  // ==============================
  // bus handshake, stop-mode quiet, wake pulse and reset checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire run = stop_mode == uwf_pkg::STOP_RUN;
  sequence s_acc;
    psel && !penable && run ##1 psel && penable && run;
  endsequence
  a_ready_late: assert property (s_acc |=> pready)
    else $error("bus answer late");
  a_ready_once: assert property (pready |=> !pready)
    else $error("bus answer held");
  a_err_alone: assert property (pslverr |-> pready)
    else $error("lone error");
  a_stop_quiet: assert property (!run && !$past(run) |-> !pready)
    else $error("answer in stop");
  a_deep_irq: assert property (stop_mode[1] [*3]
    |-> !(irq_tx || irq_rx || irq_err)) else $error("irq in deep stop");
  a_wake_only: assert property (wake_request
    |-> $past(stop_mode) == uwf_pkg::STOP_SHALLOW) else $error("bad wake");
  a_wake_pulse: assert property (wake_request |=> !wake_request)
    else $error("wake held");
  a_reset_out: assert property ($fell(rst) |-> tx_pin_out
    && !(rx_pin_release || irq_tx || irq_rx || irq_err))
    else $error("reset outputs");
endmodule // uwf_asserts
bind uwf_top uwf_asserts u_chk (.*);

// >>> test/uwf_node.sv
/* uwf_node: remote serial node driving the receive line.
   assumes BIT_CLKS bus clocks a bit; line idles high */
`timescale 1ns/10ps
module uwf_node #(parameter int BIT_CLKS = 16) (
  // clock and line
  input wire logic clk,
  output logic     line
);
  initial line = 1'b1;
  // start, data lsb first, stop, one idle bit
  task automatic send(input logic [7:0] d);
    logic [10:0] f = {2'b11, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      line <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
  endtask
  // lone low bit for the edge detector
  task automatic blip;
    @(posedge clk);
    line <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    line <= 1'b1;
  endtask
endmodule // uwf_node

// >>> test/uwf_top_test.sv
/* uwf_top_test: self-checking bench for uwf_top.
   assumes uwf_node on rx_pin and baud divisor 0 */
`timescale 1ns/10ps
module uwf_top_test;
  logic clk, rst, psel, penable, pwrite, er, wake_seen, rx_pin;
  logic pready, pslverr, tx_pin_out, tx_pin_oe, rx_pin_release;
  logic irq_tx, irq_rx, irq_err, wake_request;
  logic [4:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  uwf_pkg::uwf_stop_type stop_mode;
  int err_total, samples_checked;
  localparam logic [4:0] C1 = uwf_pkg::OFS_CTL1, C2 = uwf_pkg::OFS_CTL2,
    S1 = uwf_pkg::OFS_STAT1, S2 = uwf_pkg::OFS_STAT2,
    C3 = uwf_pkg::OFS_CTL3, DR = uwf_pkg::OFS_DATA, BR = uwf_pkg::OFS_BAUD;
  wire tx_wire = tx_pin_oe ? tx_pin_out : 1'b1; // pulled up when free
  uwf_node u_node (.clk(clk), .line(rx_pin));
  uwf_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .rx_pin(rx_pin),
    .tx_pin_in(tx_wire), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
    .rx_pin_release(rx_pin_release), .stop_mode(stop_mode),
    .irq_tx(irq_tx), .irq_rx(irq_rx), .irq_err(irq_err),
    .wake_request(wake_request));
  // ==============================
  // helpers; every wait is bounded
  task automatic end_sim;
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [4:0] a, input int d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 300);
    check("bus wait", n < 300, 1'b1);
    if (n >= 300) end_sim();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input int d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string n, input logic [4:0] a, input int m, e);
    apb(1'b0, a, 0);
    check(n, rd & m, e);
  endtask
  task automatic wait_set(input int m); // poll status until a bit sets
    int n = 0;
    do apb(1'b0, S1, 0); while ((rd & m) === 0 && ++n < 300);
    check("flag wait", n < 300, 1'b1);
    if (n >= 300) end_sim();
  endtask
  // ==============================
  // scenarios
  task automatic t_basic;
    rdchk("stat1", S1, 'hFF, 'hC0);
    rdchk("ctl2", C2, 'hFF, 'h00);
    rdchk("hole", 5'h1C, 'hFF, 'h00);
    check("hole err", er, 1'b1);
    wr(BR, 0);
    wr(C2, 'h24);
    u_node.send(8'hA5);
    wait_set('h20);
    check("irq_rx", irq_rx, 1'b1);
    rdchk("data", DR, 'hFF, 'hA5);
    rdchk("full", S1, 'h20, 'h00);
    rdchk("edge", S2, 'h40, 'h40);
    wr(S2, 'h40);
    rdchk("edge clr", S2, 'h40, 'h00);
    u_node.send(8'h11);
    u_node.send(8'h22);
    wait_set('h08);
    rdchk("overrun", S1, 'h0E, 'h08);
    rdchk("kept", DR, 'hFF, 'h11);
  endtask
  task automatic t_sleep;
    wr(C1, 'h40);
    wr(C2, 'h26);
    u_node.send(8'h12);
    u_node.send(8'h01);
    rdchk("asleep", S1, 'h20, 'h00);
    u_node.send(8'h85);
    wait_set('h20);
    rdchk("awake", C2, 'h02, 'h00);
    rdchk("mark", DR, 'hFF, 'h85);
    wr(C1, 0);
    wr(C2, 'h26);
    u_node.send(8'h01);
    repeat (192) @(posedge clk); // twelve bit times of idle
    rdchk("idle wake", C2, 'h02, 'h00);
    rdchk("no idle", S1, 'h10, 'h00);
  endtask
  task automatic t_loop;
    wr(C1, 'h10);
    wr(C2, 'h0C);
    check("rx free", rx_pin_release, 1'b1);
    wr(DR, 'h3C);
    wait_set('h20);
    rdchk("loop", DR, 'hFF, 'h3C);
    wr(C3, 'h60); // ninth bit first
    wr(C1, 'h98);
    wr(DR, 'h5A);
    wait_set('h20);
    check("drive", tx_pin_oe, 1'b1);
    rdchk("ninth", C3, 'h80, 'h80);
    rdchk("wire", DR, 'hFF, 'h5A);
  endtask
  task automatic t_stop; // entered with nothing in flight
    wr(C1, 'h80);
    wr(C2, 'h0D);
    @(posedge clk);
    stop_mode <= uwf_pkg::STOP_SHALLOW;
    u_node.blip();
    repeat (4) @(posedge clk);
    stop_mode <= uwf_pkg::STOP_RUN;
    check("wake", wake_seen, 1'b1);
    rdchk("kept", C1, 'hFF, 'h80);
    @(posedge clk);
    stop_mode <= uwf_pkg::STOP_DEEP;
    repeat (4) @(posedge clk);
    stop_mode <= uwf_pkg::STOP_RUN;
    rdchk("lost", C1, 'hFF, 'h00);
  endtask
  // ==============================
  // clock, wake monitor, main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (wake_request === 1'b1) wake_seen <= 1'b1;
  initial begin
    {rst, psel, penable, pwrite, wake_seen, paddr, pwdata} = '0;
    rst = 1'b1;
    stop_mode = uwf_pkg::STOP_RUN;
    err_total = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_basic();
    t_sleep();
    t_loop();
    t_stop();
    end_sim();
  end
endmodule // uwf_top_test
